// ---- include/drive_input_consts.vh ----
// constants for the drive input-terminal function block
`ifndef DRIVE_INPUT_CONSTS_VH
`define DRIVE_INPUT_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_SOURCE_CFG 12'h000
`define OFS_FUNC_SEL 12'h004
`define OFS_HOLD_CFG 12'h008
`define OFS_CONTROL 12'h00C
`define OFS_STATUS 12'h010
`define OFS_FREQ_REF 12'h014
`define OFS_OUT_FREQ 12'h018
`define OFS_STORED_FREQ 12'h01C
// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define FREF_SRC_LSB 0
`define RUN_SRC_LSB 4
`define FREF_SRC_RST 3'h1
`define RUN_SRC_RST 2'h1
`define FREF_SRC_MAX 3'h4
`define RUN_SRC_MAX 2'h3
`define HOLD_MEM_RST 1'h0
`define FUNC_SEL_RST 25'h0000000
// ----------------------------------------
// input function codes
// ----------------------------------------
`define FN_SRC_SWITCH 5'h01
`define FN_BLOCK_NO 5'h08
`define FN_BLOCK_NC 5'h09
`define FN_RAMP_HOLD 5'h0A
`define FN_UP 5'h10
`define FN_DOWN 5'h11
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define DEBOUNCE_NS 1000
`define DEBOUNCE_CYC ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_STEP 16'h0001
`endif

// ---- design/drive_input_terminal_functions.v ----
// input-terminal function logic: source switch, output block, ramp hold
`include "drive_input_consts.vh"
module drive_input_terminal_functions (
   // clock, enable, reset
   input wire i_ref_clk,
   input wire i_clk_en,
   input wire i_reset_n,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire o_pready,
   output reg [31:0] o_prdata,
   output wire o_pslverr,
   // contacts and panel
   input wire [4:0] i_multi_function_inputs,
   input wire i_panel_toggle_key,
   input wire i_run_cmd,
   // non-volatile store of the held frequency
   input wire [15:0] i_nv_freq,
   output reg o_nv_write,
   output reg [15:0] o_nv_freq,
   // drive stage
   output reg o_output_block,
   output reg o_speed_search,
   output reg [15:0] o_output_freq,
   output reg o_local_mode,
   output reg [2:0] o_frequency_reference_source,
   output reg [1:0] o_run_command_source,
   output reg o_invalid_input_selection_error
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [2:0] fref_src_r;
   reg [1:0] run_src_r;
   reg held_mem_r;
   reg [24:0] func_sel_r;
   reg [15:0] freq_ref_r;
   reg [15:0] stored_r;
   reg stored_valid_r;
   reg local_r;
   reg key_d_r;
   wire [4:0] filt;
   reg [15:0] out_freq_r;
   reg run_d_r;
   reg block_d_r;
   reg hold_d_r;
   reg [15:0] pre_block_ref_r;
   wire [4:0] fn_switch;
   wire [4:0] fn_no;
   wire [4:0] fn_nc;
   wire [4:0] fn_hold;
   wire [4:0] fn_up;
   wire [4:0] fn_dn;
   wire [4:0] lvl_switch;
   wire [4:0] lvl_block;
   wire [4:0] lvl_hold;
   wire wr;
   wire running;
   wire hold_on;
   wire block_on;
   wire src_switch_asg;
   wire mem_active;
   wire up_asg;
   wire dn_asg;
   wire hold_asg;
   assign wr = i_psel & i_penable & i_pwrite & i_clk_en;
   assign o_pready = 1'b1;
   assign o_pslverr = 1'b0;
   // ----------------------------------------
   // per-terminal filter and function decode
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : term
         reg [9:0] cnt_r;
         reg sync1_r;
         reg sync2_r;
         reg filt_r;
         wire [4:0] fs;
         assign fs = func_sel_r[g*5 +: 5];
         assign filt[g] = filt_r;
         always @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               sync1_r <= 1'b0;
               sync2_r <= 1'b0;
               filt_r <= 1'b0;
               cnt_r <= 10'h000;
            end else if (i_clk_en) begin
               sync1_r <= i_multi_function_inputs[g];
               sync2_r <= sync1_r;
               // level must stand steady for the whole window before it is believed
               if (sync2_r == filt_r) begin
                  cnt_r <= 10'h000;
               end else if (cnt_r == `DEBOUNCE_CYC - 1) begin
                  filt_r <= sync2_r;
                  cnt_r <= 10'h000;
               end else begin
                  cnt_r <= cnt_r + 10'h001;
               end
            end
         end
         assign fn_switch[g] = (fs == `FN_SRC_SWITCH);
         assign fn_no[g] = (fs == `FN_BLOCK_NO);
         assign fn_nc[g] = (fs == `FN_BLOCK_NC);
         assign fn_hold[g] = (fs == `FN_RAMP_HOLD);
         assign fn_up[g] = (fs == `FN_UP);
         assign fn_dn[g] = (fs == `FN_DOWN);
         assign lvl_switch[g] = fn_switch[g] & filt[g];
         assign lvl_block[g] = (fn_no[g] & filt[g]) | (fn_nc[g] & ~filt[g]);
         assign lvl_hold[g] = fn_hold[g] & filt[g];
      end
   endgenerate
   assign src_switch_asg = |fn_switch;
   assign hold_asg = |fn_hold;
   assign up_asg = |fn_up;
   assign dn_asg = |fn_dn;
   assign block_on = |lvl_block;
   assign hold_on = |lvl_hold;
   assign mem_active = held_mem_r & (hold_asg | up_asg | dn_asg);
   assign running = run_d_r;
   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fref_src_r <= `FREF_SRC_RST;
         run_src_r <= `RUN_SRC_RST;
         held_mem_r <= `HOLD_MEM_RST;
         func_sel_r <= `FUNC_SEL_RST;
         freq_ref_r <= 16'h0000;
      end else if (wr) begin
         if (i_paddr == `OFS_SOURCE_CFG && !running) begin
            // out-of-range values are dropped and the old setting kept
            if (i_pwdata[`FREF_SRC_LSB +: 3] <= `FREF_SRC_MAX) begin
               fref_src_r <= i_pwdata[`FREF_SRC_LSB +: 3];
            end
            run_src_r <= i_pwdata[`RUN_SRC_LSB +: 2];
         end
         if (i_paddr == `OFS_HOLD_CFG && !running) begin
            held_mem_r <= i_pwdata[0];
         end
         if (i_paddr == `OFS_FUNC_SEL) begin
            func_sel_r <= i_pwdata[24:0];
         end
         if (i_paddr == `OFS_FREQ_REF) begin
            freq_ref_r <= i_pwdata[15:0];
         end
      end
   end
   // ----------------------------------------
   // register reads
   // ----------------------------------------
   always @* begin
      case (i_paddr)
         `OFS_SOURCE_CFG: o_prdata = {26'h0000000, run_src_r, 1'b0, fref_src_r};
         `OFS_FUNC_SEL: o_prdata = {7'h00, func_sel_r};
         `OFS_HOLD_CFG: o_prdata = {31'h00000000, held_mem_r};
         `OFS_STATUS: o_prdata = {26'h0000000, o_invalid_input_selection_error,
                                  hold_on, block_on, local_r, 1'b0, running};
         `OFS_FREQ_REF: o_prdata = {16'h0000, freq_ref_r};
         `OFS_OUT_FREQ: o_prdata = {16'h0000, out_freq_r};
         `OFS_STORED_FREQ: o_prdata = {16'h0000, stored_r};
         default: o_prdata = 32'h00000000;
      endcase
   end
   // ----------------------------------------
   // local/remote selection
   // ----------------------------------------
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         local_r <= 1'b0;
         key_d_r <= 1'b0;
      end else if (i_clk_en) begin
         key_d_r <= i_panel_toggle_key;
         if (src_switch_asg) begin
            local_r <= |lvl_switch;
         end else if (i_panel_toggle_key && !key_d_r) begin
            local_r <= ~local_r;
         end
      end
   end
   // ----------------------------------------
   // ramp, hold, block
   // ----------------------------------------
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_freq_r <= 16'h0000;
         run_d_r <= 1'b0;
         block_d_r <= 1'b0;
         hold_d_r <= 1'b0;
         pre_block_ref_r <= 16'h0000;
         stored_r <= 16'h0000;
         stored_valid_r <= 1'b0;
         o_nv_write <= 1'b0;
         o_nv_freq <= 16'h0000;
         o_speed_search <= 1'b0;
      end else if (i_clk_en) begin
         run_d_r <= i_run_cmd;
         block_d_r <= block_on;
         hold_d_r <= hold_on;
         o_nv_write <= 1'b0;
         o_speed_search <= 1'b0;
         // stored value is fetched from the external store once after reset
         if (!stored_valid_r) begin
            stored_r <= i_nv_freq;
            stored_valid_r <= 1'b1;
         end
         if (block_on && !block_d_r) begin
            pre_block_ref_r <= out_freq_r;
         end
         if (i_run_cmd && !run_d_r && hold_on) begin
            out_freq_r <= mem_active ? stored_r : 16'h0000;
         end else if (!i_run_cmd) begin
            out_freq_r <= mem_active ? out_freq_r : 16'h0000;
         end else if (block_on) begin
            out_freq_r <= out_freq_r;
         end else if (block_d_r) begin
            out_freq_r <= pre_block_ref_r;
            o_speed_search <= 1'b1;
         end else if (hold_on) begin
            out_freq_r <= out_freq_r;
         end else if (out_freq_r < freq_ref_r) begin
            out_freq_r <= out_freq_r + `RAMP_STEP;
         end else if (out_freq_r > freq_ref_r) begin
            out_freq_r <= out_freq_r - `RAMP_STEP;
         end
         if (hold_on && !hold_d_r && held_mem_r && i_run_cmd) begin
            stored_r <= out_freq_r;
            o_nv_write <= 1'b1;
            o_nv_freq <= out_freq_r;
         end
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_output_block <= 1'b0;
         o_output_freq <= 16'h0000;
         o_local_mode <= 1'b0;
         o_frequency_reference_source <= `FREF_SRC_RST;
         o_run_command_source <= `RUN_SRC_RST;
         o_invalid_input_selection_error <= 1'b0;
      end else if (i_clk_en) begin
         o_output_block <= block_on;
         o_output_freq <= block_on ? 16'h0000 : out_freq_r;
         o_local_mode <= local_r;
         // local means the panel drives both run and reference
         o_frequency_reference_source <= local_r ? 3'h0 : fref_src_r;
         o_run_command_source <= local_r ? 2'h0 : run_src_r;
         o_invalid_input_selection_error <= (up_asg ^ dn_asg) | ((up_asg | dn_asg) & hold_asg);
      end
   end
endmodule

// ---- test/drive_input_properties.sv ----
// port-level checker for the drive input-terminal block
module drive_input_properties (
   input wire i_ref_clk, input wire i_reset_n, input wire i_clk_en,
   input wire o_pready, input wire o_pslverr, input wire o_nv_write,
   input wire o_output_block, input wire o_speed_search, input wire o_local_mode,
   input wire [15:0] o_output_freq,
   input wire [2:0] o_frequency_reference_source,
   input wire [1:0] o_run_command_source
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // two samples so a one-cycle register skew cannot fire it
   sequence s_blocked;
      o_output_block [*2];
   endsequence
   sequence s_local;
      o_local_mode [*2];
   endsequence
   chk_bus_ready: assert property (o_pready && !o_pslverr)
      else $error("apb answer not zero-wait okay");
   chk_reset_srcs: assert property ($rose(i_reset_n) |->
      o_frequency_reference_source == 3'h1 && o_run_command_source == 2'h1)
      else $error("sources not 1 after reset");
   chk_ref_range: assert property (o_frequency_reference_source <= 3'h4)
      else $error("reference source above 4");
   chk_block_zero: assert property (s_blocked |-> o_output_freq == 16'h0000)
      else $error("frequency nonzero while blocked");
   chk_local_srcs: assert property (s_local |->
      o_frequency_reference_source == 3'h0 && o_run_command_source == 2'h0)
      else $error("local mode without panel sources");
   chk_search_pulse: assert property (o_speed_search |->
      !o_output_block ##1 !o_speed_search)
      else $error("speed search not a release pulse");
   chk_nv_pulse: assert property (o_nv_write |=> !o_nv_write)
      else $error("store strobe longer than one cycle");
   chk_enable_freeze: assert property (!i_clk_en |=>
      $stable(o_output_freq) && $stable(o_output_block))
      else $error("state moved with clock enable low");
endmodule
bind drive_input_terminal_functions drive_input_properties chk (
   .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_nv_write(o_nv_write),
   .o_output_block(o_output_block), .o_speed_search(o_speed_search),
   .o_local_mode(o_local_mode), .o_output_freq(o_output_freq),
   .o_frequency_reference_source(o_frequency_reference_source),
   .o_run_command_source(o_run_command_source));

// ---- test/contact_panel_model.sv ----
// contacts that bounce before settling, plus the non-volatile frequency store
module contact_panel_model (
   input wire logic i_clk,
   input wire logic [4:0] i_want,
   input wire logic i_nv_write,
   input wire logic [15:0] i_nv_freq,
   output logic [4:0] o_contacts,
   output logic [15:0] o_nv_freq
);
   timeunit 1ns;
   timeprecision 1ps;
   int bounce = 0;
   logic [4:0] mask = 5'h00;
   initial o_contacts = 5'h00;
   initial o_nv_freq = 16'h0000;
   always @(posedge i_clk) begin
      // each change chatters a few cycles, so the filter must earn its keep
      if (bounce == 0 && i_want != o_contacts) begin
         bounce <= 5;
         mask <= i_want ^ o_contacts;
      end else if (bounce > 1) begin
         bounce <= bounce - 1;
         o_contacts <= o_contacts ^ mask;
      end else if (bounce == 1) begin
         bounce <= 0;
         o_contacts <= i_want;
      end
      if (i_nv_write) o_nv_freq <= i_nv_freq;
   end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the drive input-terminal block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, en = 1, sel = 0, ena = 0, wr = 0, key = 0, run = 0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wd = 32'h0, rdv, prdata;
   logic [4:0] want = 5'h00, cont;
   logic [15:0] nvq, nvd, freq, f1;
   logic rdy, nvw, blk, srch, loc, err;
   int srch_count = 0, n0 = 0;
   logic [2:0] fsrc;
   logic [1:0] rsrc;
   int errors = 0, checks_done = 0;
   always #10 clk = ~clk;
   always @(posedge clk) if (srch === 1'b1) srch_count <= srch_count + 1;
   contact_panel_model partner (.i_clk(clk), .i_want(want), .i_nv_write(nvw),
      .i_nv_freq(nvd), .o_contacts(cont), .o_nv_freq(nvq));
   drive_input_terminal_functions dut (.i_ref_clk(clk), .i_clk_en(en), .i_reset_n(rst_n),
      .i_psel(sel), .i_penable(ena), .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd),
      .o_pready(rdy), .o_prdata(prdata), .o_pslverr(), .i_multi_function_inputs(cont),
      .i_panel_toggle_key(key), .i_run_cmd(run), .i_nv_freq(nvq), .o_nv_write(nvw),
      .o_nv_freq(nvd), .o_output_block(blk), .o_speed_search(srch), .o_output_freq(freq),
      .o_local_mode(loc), .o_frequency_reference_source(fsrc),
      .o_run_command_source(rsrc), .o_invalid_input_selection_error(err));
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // apb cycle: setup, then access held until pready is sampled high
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
      sel <= 1;
      ena <= 0;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      ena <= 1;
      do @(posedge clk); while (rdy !== 1'b1);
      rdv = prdata;
      sel <= 0;
      ena <= 0;
      @(posedge clk);
   endtask
   task automatic t_regs;
      bus(0, 12'h000, 0);
      chk("src reset", 32'h11, rdv);
      bus(0, 12'h008, 0);
      chk("mem reset", 32'h0, rdv);
      bus(0, 12'h00C, 0);
      chk("unmapped", 32'h0, rdv);
      bus(1, 12'h000, 32'h15);
      bus(0, 12'h000, 0);
      chk("ref 5", 32'h11, rdv);
      bus(1, 12'h000, 32'h34);
      bus(0, 12'h000, 0);
      chk("ref 4", 32'h34, rdv);
      chk("eff ref", 3'h4, fsrc);
      chk("eff run", 2'h3, rsrc);
      // with no source-switch input the panel key still toggles
      key <= 1;
      cyc(3);
      key <= 0;
      cyc(3);
      chk("key local", 1, loc);
      chk("panel ref", 0, fsrc);
      key <= 1;
      cyc(3);
      key <= 0;
      cyc(3);
      chk("key remote", 0, loc);
      bus(1, 12'h000, 32'h11);
      en <= 0;
      cyc(3);
      en <= 1;
      $display("regs done");
   endtask
   // contact waits cover bounce, two sync stages, the filter and the output register
   task automatic t_switch;
      bus(1, 12'h004, 32'h1);
      want <= 5'h01;
      cyc(70);
      chk("local", 1, loc);
      chk("ref src", 0, fsrc);
      chk("run src", 0, rsrc);
      key <= 1;
      cyc(3);
      key <= 0;
      cyc(3);
      chk("key ignored", 1, loc);
      want <= 5'h00;
      cyc(70);
      chk("remote", 0, loc);
      chk("ref back", 1, fsrc);
      chk("run back", 1, rsrc);
      $display("switch done");
   endtask
   task automatic t_block;
      bus(1, 12'h004, 32'h100);
      bus(1, 12'h014, 32'h200);
      run <= 1;
      cyc(60);
      bus(1, 12'h000, 32'h00);
      bus(0, 12'h000, 0);
      chk("run lock", 32'h11, rdv);
      bus(1, 12'h008, 32'h1);
      bus(0, 12'h008, 0);
      chk("mem lock", 32'h0, rdv);
      f1 = freq;
      // a block and release through the NO input, then a second one through the NC input, both while running
      want <= 5'h02;
      cyc(70);
      chk("no block", 1, blk);
      chk("blk freq", 0, freq);
      bus(0, 12'h010, 0);
      chk("status", 32'h9, rdv);
      n0 = srch_count;
      want <= 5'h00;
      cyc(70);
      chk("released", 0, blk);
      chk("search", n0 + 1, srch_count);
      chk("resume", 1, freq > f1);
      bus(1, 12'h004, 32'h120);
      cyc(5);
      chk("nc block", 1, blk);
      want <= 5'h02;
      cyc(70);
      chk("nc release", 0, blk);
      want <= 5'h00;
      run <= 0;
      cyc(2);
      $display("block done");
   endtask
   task automatic t_hold;
      bus(1, 12'h004, 32'h2800);
      bus(1, 12'h008, 32'h1);
      run <= 1;
      cyc(20);
      want <= 5'h04;
      cyc(70);
      f1 = freq;
      cyc(20);
      chk("held", f1, freq);
      chk("nv kept", f1, nvq);
      bus(0, 12'h018, 0);
      chk("out reg", f1, rdv);
      // power cycle: only the external store keeps the held value
      run <= 0;
      rst_n <= 0;
      cyc(2);
      rst_n <= 1;
      cyc(2);
      bus(1, 12'h004, 32'h2800);
      bus(1, 12'h008, 32'h1);
      bus(1, 12'h014, 32'h200);
      cyc(70);
      bus(0, 12'h01C, 0);
      chk("stored reg", f1, rdv);
      run <= 1;
      cyc(5);
      chk("stored start", f1, freq);
      run <= 0;
      cyc(2);
      bus(1, 12'h008, 32'h0);
      run <= 1;
      cyc(5);
      chk("zero start", 0, freq);
      want <= 5'h00;
      cyc(70);
      chk("ramps", 1, freq > 16'h0000);
      run <= 0;
      cyc(2);
      bus(1, 12'h004, 32'h80000);
      cyc(3);
      chk("up alone", 1, err);
      bus(1, 12'h004, 32'h1180000);
      cyc(3);
      chk("up down pair", 0, err);
      bus(1, 12'h004, 32'h82800);
      cyc(3);
      chk("up with hold", 1, err);
      bus(1, 12'h004, 32'h0);
      cyc(3);
      chk("err clear", 0, err);
      $display("hold done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      cyc(6);
      rst_n <= 1;
      @(posedge clk);
      t_regs;
      t_switch;
      t_block;
      t_hold;
      wrap_up;
   end
   initial begin
      cyc(6000);
      errors++;
      wrap_up;
   end
endmodule
